// >>> pkt_spi_map.svh
/*
  Holds the register offsets, field positions, reset values and sizes used by the packet buffer serial access block.
  Assumes that it is included by bare name from every file that needs these values.
*/
`ifndef PKT_SPI_MAP_SVH
`define PKT_SPI_MAP_SVH

// ----------------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------------
`define ADDR_SOFT_RESET    6'h00
`define ADDR_RX_BUF_PORT   6'h01
`define ADDR_TX_BUF_PORT   6'h02
`define ADDR_TX_PKT_CTL    6'h03
`define ADDR_IRQ_MASK      6'h05
`define ADDR_IRQ_FLAGS     6'h24
`define ADDR_LAST          6'h3F
`define ADDR_ROLLOVER      6'h03

// ----------------------------------------------------------------------------
// Field positions and reset values
// ----------------------------------------------------------------------------
`define BIT_OVERRUN_FLAG   14
`define BIT_CONTEND_FLAG   13
`define BIT_OVERRUN_MASK   12
`define BIT_CONTEND_MASK   11
`define BIT_TX_BUF_SELECT  15
`define TX_LEN_MSB         6
`define TX_LEN_MAX         7'h7F
`define RST_TX_PKT_CTL     16'h0000
`define RST_IRQ_MASK       16'h0000
`define BUF_WORDS          64
`define BUF_AW             6

`endif

// >>> pkt_spi_pkg.sv
/*
  Holds the types shared by the serial link and core sides of the buffer access block.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package pkt_spi_pkg;
  typedef enum logic [1:0] {
    LINK_HDR  = 2'b00,
    LINK_DATA = 2'b01
  } link_state_t;

  typedef struct packed {
    logic        write;
    logic [5:0]  addr;
    logic [15:0] data;
  } word_xfer_t;
endpackage : pkt_spi_pkg

// >>> spi_host_model.sv
/*
  Holds a behavioural serial bus master that stands in for the host controller.
  Assumes mode 0 timing, MSB first, a 160 ns serial clock that runs only inside frames.
*/
`timescale 1ns/1ps
`default_nettype none
module spi_host_model (
  output logic        serial_clock,
  output logic        chip_sel_n,
  output logic        mosi,
  input  wire logic   miso,
  output logic [15:0] rd_word,
  output logic        rd_pulse
);
  initial begin
    serial_clock = 1'b0;
    chip_sel_n   = 1'b1;
    mosi         = 1'b0;
    rd_word      = 16'h0000;
    rd_pulse     = 1'b0;
  end

  // Data changes while the clock is low and is sampled at the rising edge.
  task automatic shift(input logic [15:0] v, input int nb, output logic [15:0] r);
    r = 16'h0000;
    for (int b = nb - 1; b >= 0; b--) begin
      mosi = v[b];
      #80;
      serial_clock = 1'b1;
      r = {r[14:0], miso};
      #80;
      serial_clock = 1'b0;
    end
  endtask : shift

  // One frame: header, n whole words, then an idle hold with select still low.
  task automatic frame(input logic rd, input logic [5:0] a, input logic [15:0] w[$], input int n,
                       input logic rep, input int hold);
    logic [15:0] r;
    chip_sel_n = 1'b0;
    #80;
    shift({8'h00, rd, 1'b0, a}, 8, r);
    for (int i = 0; i < n; i++) begin
      shift((i < w.size()) ? w[i] : 16'hA5A5, 16, r);
      if (rep) begin
        rd_word = r;
        rd_pulse = 1'b1;
        #1;
        rd_pulse = 1'b0;
      end
    end
    #(hold);
    #80;
    chip_sel_n = 1'b1;
    // The line is not held at the last bit once the frame is over.
    mosi = ~mosi;
    #160;
  endtask : frame
endmodule : spi_host_model
`default_nettype wire

// >>> spi_link_shift.sv
/*
  Holds the serial-clock side: it shifts in the header and 16-bit words, shifts out read data.
  Assumes mode 0 timing, MSB first, and chip select active low which also clears the count, shift and output registers, but not the toggles or xfer.
  Assumes link_rst comes from the core reset and is held while the serial clock is stopped.
*/
`timescale 1ns/1ps
`default_nettype none
module spi_link_shift
  import pkt_spi_pkg::*;
(
  input  wire logic        serial_clock,
  input  wire logic        chip_sel_n,
  input  wire logic        link_rst,
  input  wire logic        mosi,
  output logic             miso,
  input  wire logic [15:0] rd_word,
  output logic             hdr_toggle,
  output logic             word_toggle,
  output word_xfer_t       xfer
);
  logic [4:0]  bit_cnt_reg;
  logic [15:0] sh_reg;
  logic [15:0] out_reg;
  link_state_t state_reg;
  wire  [15:0] sh_next = {sh_reg[14:0], mosi};

  // Chip select high clears the link state, since the serial clock stops outside frames.
  always_ff @(posedge serial_clock or posedge chip_sel_n) begin
    if (chip_sel_n) begin
      bit_cnt_reg <= 5'h00;
      sh_reg      <= 16'h0000;
      state_reg   <= LINK_HDR;
    end else begin
      sh_reg <= sh_next;
      if (state_reg == LINK_HDR && bit_cnt_reg == 5'h07) begin
        state_reg   <= LINK_DATA;
        bit_cnt_reg <= 5'h00;
      end else if (bit_cnt_reg == 5'h0F) begin
        bit_cnt_reg <= 5'h00;
      end else begin
        bit_cnt_reg <= bit_cnt_reg + 5'h01;
      end
    end
  end

  // Header and word events are toggles so the core side can catch them in its own clock.
  // They survive chip select and clear only with the core reset, so both ends of each crossing start equal.
  always_ff @(posedge serial_clock or posedge link_rst) begin
    if (link_rst) begin
      hdr_toggle  <= 1'b0;
      word_toggle <= 1'b0;
      xfer        <= '0;
    end else begin
      if (!chip_sel_n && state_reg == LINK_HDR && bit_cnt_reg == 5'h07) begin
        xfer.write <= ~sh_next[7];
        xfer.addr  <= sh_next[5:0];
        hdr_toggle <= ~hdr_toggle;
      end
      if (!chip_sel_n && state_reg == LINK_DATA && bit_cnt_reg == 5'h0F) begin
        xfer.data   <= sh_next;
        word_toggle <= ~word_toggle;
      end
    end
  end

  always_ff @(negedge serial_clock or posedge chip_sel_n) begin
    if (chip_sel_n) begin
      out_reg <= 16'h0000;
    end else if (state_reg == LINK_DATA && bit_cnt_reg == 5'h00) begin
      out_reg <= rd_word;
    end else begin
      out_reg <= {out_reg[14:0], 1'b0};
    end
  end

  assign miso = out_reg[15];
endmodule : spi_link_shift
`default_nettype wire

// >>> spi_packet_buffer_access.sv
/*
  Holds the core-clock side of the packet buffer access: registers, buffers, pointers, error flags, soft reset.
  Assumes the host is a serial master and the radio sequencer presents its buffer requests on the core clock.
*/
`timescale 1ns/1ps
`default_nettype none
`include "pkt_spi_map.svh"
module spi_packet_buffer_access
  import pkt_spi_pkg::*;
#(
  parameter int WORDS = `BUF_WORDS
) (
  input  wire logic        clock,
  input  wire logic        sys_rst,
  input  wire logic        serial_clock,
  input  wire logic        chip_sel_n,
  input  wire logic        mosi,
  output logic             miso,
  input  wire logic        rx_seq_active,
  input  wire logic        rx_seq_we,
  input  wire logic [5:0]  rx_seq_addr,
  input  wire logic [15:0] rx_seq_wdata,
  input  wire logic        tx_seq_active,
  input  wire logic        tx_seq_re,
  input  wire logic [5:0]  tx_seq_addr,
  output logic [15:0]      tx_seq_rdata,
  output logic             tx_buffer_select,
  output logic [6:0]       tx_length,
  output logic             soft_reset,
  output logic             irq
);
  // --------------------------------------------------------------------------
  // Link side and crossings
  // --------------------------------------------------------------------------
  logic        hdr_tog;
  logic        word_tog;
  word_xfer_t  xfer;
  logic [15:0] rd_word_reg;
  logic        hdr_s;
  logic        word_s;
  logic        cs_n_s;
  logic        hdr_d_reg;
  logic        word_d_reg;

  // The link side has no clock while idle, so the core reset clears its toggles directly.
  spi_link_shift u_link (
    .serial_clock (serial_clock),
    .link_rst     (sys_rst),
    .chip_sel_n   (chip_sel_n),
    .mosi         (mosi),
    .miso         (miso),
    .rd_word      (rd_word_reg),
    .hdr_toggle   (hdr_tog),
    .word_toggle  (word_tog),
    .xfer         (xfer)
  );

  sync_bit u_sync_hdr  (.clock(clock), .sys_rst(sys_rst), .din(hdr_tog),    .dout(hdr_s));
  sync_bit u_sync_word (.clock(clock), .sys_rst(sys_rst), .din(word_tog),   .dout(word_s));
  sync_bit u_sync_cs   (.clock(clock), .sys_rst(sys_rst), .din(chip_sel_n), .dout(cs_n_s));

  // The captured header and word stay stable for many core cycles after their toggle.
  wire hdr_evt  = hdr_s ^ hdr_d_reg;
  wire word_evt = word_s ^ word_d_reg;

  // --------------------------------------------------------------------------
  // Transaction state
  // --------------------------------------------------------------------------
  logic       active_reg;
  logic       wr_reg;
  logic [5:0] addr_reg;
  logic [6:0] wptr_reg;
  logic       srst_reg;

  wire core_rst = sys_rst | srst_reg;
  wire is_rx_port = active_reg && addr_reg == `ADDR_RX_BUF_PORT;
  wire is_tx_port = active_reg && addr_reg == `ADDR_TX_BUF_PORT;
  wire in_range   = (wptr_reg < 7'(WORDS));
  wire host_rx_rd = is_rx_port && !wr_reg;
  wire host_tx_wr = is_tx_port && wr_reg;
  wire buf_word   = word_evt && (is_rx_port || is_tx_port);
  wire start_soft = hdr_evt && xfer.write && xfer.addr == `ADDR_SOFT_RESET;

  // --------------------------------------------------------------------------
  // Buffers, kept across soft reset
  // --------------------------------------------------------------------------
  logic [15:0] rx_mem  [WORDS];
  logic [15:0] tx_mem0 [WORDS];
  logic [15:0] tx_mem1 [WORDS];

  wire rx_contend = host_rx_rd && rx_seq_active && rx_seq_we;
  wire tx_contend = host_tx_wr && tx_seq_active && tx_seq_re;
  // Internal sequence owns the port in a clash, so the host word is dropped.
  wire host_wr_ok = word_evt && host_tx_wr && in_range && !tx_contend;
  wire [5:0] wp6  = wptr_reg[5:0];

  always_ff @(posedge clock) begin
    if (rx_seq_active && rx_seq_we) begin
      rx_mem[rx_seq_addr] <= rx_seq_wdata;
    end
    if (host_wr_ok && !tx_buffer_select) begin
      tx_mem0[wp6] <= xfer.data;
    end
    if (host_wr_ok && tx_buffer_select) begin
      tx_mem1[wp6] <= xfer.data;
    end
  end

  // The sequencer reads only frame bytes; it builds the checksum itself.
  always_ff @(posedge clock) begin
    tx_seq_rdata <= tx_buffer_select ? tx_mem1[tx_seq_addr] : tx_mem0[tx_seq_addr];
  end

  // --------------------------------------------------------------------------
  // Registers
  // --------------------------------------------------------------------------
  logic [15:0] tx_ctl_reg;
  logic [15:0] mask_reg;
  logic [15:0] flags_reg;
  logic        ovr_set;
  logic        flag_clr;

  assign ovr_set  = buf_word && !in_range;
  assign flag_clr = hdr_evt && !xfer.write && xfer.addr == `ADDR_IRQ_FLAGS;
  assign tx_buffer_select = tx_ctl_reg[`BIT_TX_BUF_SELECT];
  assign tx_length        = tx_ctl_reg[`TX_LEN_MSB:0];
  assign soft_reset       = srst_reg;

  // Register writes from the host; the address pointer walks for plain registers.
  wire reg_wr = word_evt && active_reg && wr_reg && !is_tx_port && !is_rx_port;

  always_ff @(posedge clock) begin
    if (core_rst) begin
      tx_ctl_reg <= `RST_TX_PKT_CTL;
      mask_reg   <= `RST_IRQ_MASK;
    end else if (reg_wr && addr_reg == `ADDR_TX_PKT_CTL) begin
      tx_ctl_reg <= xfer.data;
    end else if (reg_wr && addr_reg == `ADDR_IRQ_MASK) begin
      mask_reg <= xfer.data;
    end
  end

  // Set wins over a clear arriving in the same cycle.
  always_ff @(posedge clock) begin
    if (core_rst) begin
      flags_reg <= 16'h0000;
    end else begin
      flags_reg[`BIT_OVERRUN_FLAG] <= ovr_set |
        (flags_reg[`BIT_OVERRUN_FLAG] & ~flag_clr);
      flags_reg[`BIT_CONTEND_FLAG] <= (rx_contend | tx_contend) |
        (flags_reg[`BIT_CONTEND_FLAG] & ~flag_clr);
    end
  end

  always_ff @(posedge clock) begin
    if (core_rst) begin
      irq <= 1'b0;
    end else begin
      irq <= (flags_reg[`BIT_OVERRUN_FLAG] & mask_reg[`BIT_OVERRUN_MASK]) |
             (flags_reg[`BIT_CONTEND_FLAG] & mask_reg[`BIT_CONTEND_MASK]);
    end
  end

  // --------------------------------------------------------------------------
  // Transaction pointers and soft reset
  // --------------------------------------------------------------------------
  wire [5:0] addr_next = (addr_reg == `ADDR_LAST) ? `ADDR_ROLLOVER : addr_reg + 6'h01;

  always_ff @(posedge clock) begin
    if (sys_rst || cs_n_s) begin
      active_reg <= 1'b0;
      wr_reg     <= 1'b0;
      addr_reg   <= 6'h00;
      wptr_reg   <= 7'h00;
    end else if (hdr_evt) begin
      active_reg <= 1'b1;
      wr_reg     <= xfer.write;
      addr_reg   <= xfer.addr;
      wptr_reg   <= 7'h00;
    end else if (word_evt) begin
      if (is_tx_port || is_rx_port) begin
        if (wptr_reg != 7'h7F) begin
          wptr_reg <= wptr_reg + 7'h01;
        end
      end else begin
        addr_reg <= addr_next;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst || cs_n_s) begin
      srst_reg <= 1'b0;
    end else if (start_soft) begin
      srst_reg <= 1'b1;
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      hdr_d_reg  <= 1'b0;
      word_d_reg <= 1'b0;
    end else begin
      hdr_d_reg  <= hdr_s;
      word_d_reg <= word_s;
    end
  end

  // --------------------------------------------------------------------------
  // Read data for the next outgoing word
  // --------------------------------------------------------------------------
  logic [15:0] reg_rdata;
  always_comb begin
    case (addr_reg)
      `ADDR_TX_PKT_CTL: reg_rdata = tx_ctl_reg;
      `ADDR_IRQ_MASK:   reg_rdata = mask_reg;
      `ADDR_IRQ_FLAGS:  reg_rdata = flags_reg;
      `ADDR_TX_BUF_PORT: reg_rdata = tx_buffer_select ? tx_mem1[wp6] : tx_mem0[wp6];
      default:          reg_rdata = 16'h0000;
    endcase
  end

  // Read data is fetched one word ahead, since the link loads it as soon as the previous word ends.
  // The header reaches this clock too late for the word that follows it, so that word is a dummy.
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      rd_word_reg <= 16'h0000;
    end else if (is_rx_port) begin
      rd_word_reg <= in_range ? rx_mem[wp6] : 16'h0000;
    end else if (hdr_evt && !xfer.write && xfer.addr == `ADDR_IRQ_FLAGS) begin
      rd_word_reg <= flags_reg;
    end else if (!flag_clr && !(active_reg && addr_reg == `ADDR_IRQ_FLAGS)) begin
      rd_word_reg <= reg_rdata;
    end
  end

  // --------------------------------------------------------------------------
  // Checks
  // --------------------------------------------------------------------------
  property p_overrun;
    @(posedge clock) disable iff (core_rst) ovr_set |=> flags_reg[`BIT_OVERRUN_FLAG];
  endproperty
  a_overrun: assert property (p_overrun) else $error("overrun not flagged");

  property p_irq;
    @(posedge clock) disable iff (core_rst)
      (flags_reg[`BIT_OVERRUN_FLAG] && mask_reg[`BIT_OVERRUN_MASK]) |=> irq;
  endproperty
  a_irq: assert property (p_irq) else $error("masked overrun irq missing");

  property p_contend;
    @(posedge clock) disable iff (core_rst) (rx_contend || tx_contend) |=> flags_reg[`BIT_CONTEND_FLAG];
  endproperty
  a_contend: assert property (p_contend) else $error("contention not flagged");

  property p_clear;
    @(posedge clock) disable iff (core_rst)
      (flag_clr && !ovr_set) |=> !flags_reg[`BIT_OVERRUN_FLAG];
  endproperty
  a_clear: assert property (p_clear) else $error("read did not clear");

  property p_start;
    @(posedge clock) disable iff (sys_rst || cs_n_s) hdr_evt |=> wptr_reg == 7'h00;
  endproperty
  a_start: assert property (p_start) else $error("pointer not at zero");

  property p_soft;
    @(posedge clock) disable iff (sys_rst || cs_n_s) start_soft |=> srst_reg;
  endproperty
  a_soft: assert property (p_soft) else $error("soft reset not raised");

  property p_noread_reset;
    @(posedge clock) disable iff (sys_rst)
      (hdr_evt && !xfer.write && !srst_reg) |=> !srst_reg;
  endproperty
  a_noread_reset: assert property (p_noread_reset) else $error("read caused reset");

  property p_port_hold;
    @(posedge clock) disable iff (sys_rst || cs_n_s)
      (word_evt && is_tx_port) |=> addr_reg == `ADDR_TX_BUF_PORT;
  endproperty
  a_port_hold: assert property (p_port_hold) else $error("address moved");

  property p_irq_contend;
    @(posedge clock) disable iff (core_rst)
      (flags_reg[`BIT_CONTEND_FLAG] && mask_reg[`BIT_CONTEND_MASK]) |=> irq;
  endproperty
  a_irq_contend: assert property (p_irq_contend) else $error("masked contention irq missing");

  property p_clear_contend;
    @(posedge clock) disable iff (core_rst)
      (flag_clr && !rx_contend && !tx_contend) |=> !flags_reg[`BIT_CONTEND_FLAG];
  endproperty
  a_clear_contend: assert property (p_clear_contend) else $error("read did not clear contention");

  property p_soft_hold;
    @(posedge clock) disable iff (sys_rst)
      (srst_reg && !cs_n_s) |=> srst_reg;
  endproperty
  a_soft_hold: assert property (p_soft_hold) else $error("soft reset dropped while selected");

  c_overrun: cover property (@(posedge clock) ovr_set);
  c_rx_contend: cover property (@(posedge clock) rx_contend);
  c_contend: cover property (@(posedge clock) tx_contend);
  c_soft:    cover property (@(posedge clock) start_soft);
endmodule : spi_packet_buffer_access
`default_nettype wire

// >>> sync_bit.sv
/*
  Holds a two flip-flop level synchroniser.
  Assumes the input is a level from another clock domain.
*/
`timescale 1ns/1ps
`default_nettype none
module sync_bit (
  input  wire logic clock,
  input  wire logic sys_rst,
  input  wire logic din,
  output logic      dout
);
  logic meta_reg;

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      meta_reg <= 1'b0;
      dout     <= 1'b0;
    end else begin
      meta_reg <= din;
      dout     <= meta_reg;
    end
  end
endmodule : sync_bit
`default_nettype wire

// >>> tb_spi_packet_buffer_access.sv
/*
  Holds the self-checking bench of the packet buffer serial access block.
  Assumes the host model file and the design files are compiled before it.
*/
`timescale 1ns/1ps
`default_nettype none
`include "pkt_spi_map.svh"
module tb_spi_packet_buffer_access;
  import pkt_spi_pkg::*;
  localparam int LIMIT = 60000;
  logic        clock = 1'b0;
  logic        sys_rst, serial_clock, chip_sel_n, mosi, miso, rd_pulse, re_d;
  logic        rx_seq_active, rx_seq_we, tx_seq_active, tx_seq_re;
  logic [5:0]  rx_seq_addr, tx_seq_addr;
  logic [15:0] rx_seq_wdata, tx_seq_rdata, rd_word;
  logic        tx_buffer_select, soft_reset, irq;
  logic [6:0]  tx_length, len;
  logic [15:0] wq[$], nq[$], q_spi[$], q_seq[$];
  int          miscompares = 0, n_checks = 0, cycles = 0, n;

  always #25 clock = ~clock;

  spi_packet_buffer_access #(.WORDS(`BUF_WORDS)) i_spi_packet_buffer_access (
    .clock(clock), .sys_rst(sys_rst), .serial_clock(serial_clock), .chip_sel_n(chip_sel_n),
    .mosi(mosi), .miso(miso), .rx_seq_active(rx_seq_active), .rx_seq_we(rx_seq_we),
    .rx_seq_addr(rx_seq_addr), .rx_seq_wdata(rx_seq_wdata), .tx_seq_active(tx_seq_active),
    .tx_seq_re(tx_seq_re), .tx_seq_addr(tx_seq_addr), .tx_seq_rdata(tx_seq_rdata),
    .tx_buffer_select(tx_buffer_select), .tx_length(tx_length), .soft_reset(soft_reset), .irq(irq));
  spi_host_model i_spi_host_model (
    .serial_clock(serial_clock), .chip_sel_n(chip_sel_n), .mosi(mosi), .miso(miso),
    .rd_word(rd_word), .rd_pulse(rd_pulse));

  // ---------------------------------------------------------------------------
  // Compare and report
  // ---------------------------------------------------------------------------
  task automatic check_word(input logic [15:0] got, input logic [15:0] exp, input string what);
    n_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask : check_word

  task automatic check_flag(input logic got, input logic exp, input string what);
    n_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected at %0t: %s got %b expected %b", $time, what, got, exp);
    end
  endtask : check_flag

  task automatic wrap_up();
    if (miscompares == 0 && n_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : wrap_up

  always @(posedge rd_pulse) check_word(rd_word, (q_spi.size() > 0) ? q_spi.pop_front() : 16'hXXXX, "serial read");
  always @(posedge clock) re_d <= tx_seq_re & tx_seq_active;
  always @(negedge clock) if (re_d) check_word(tx_seq_rdata, q_seq.pop_front(), "sequencer read");
  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == LIMIT) begin
      miscompares++;
      wrap_up();
    end
  end

  // ---------------------------------------------------------------------------
  // Drivers
  // ---------------------------------------------------------------------------
  task automatic settle();
    repeat (10) @(negedge clock);
  endtask : settle

  task automatic wreg(input logic [5:0] a, input logic [15:0] v);
    i_spi_host_model.frame(1'b0, a, {v}, 1, 1'b0, 0);
    settle();
  endtask : wreg

  // Every read opens with a dummy word: the header reaches the core clock only after that word has started.
  task automatic rreg(input logic [5:0] a, input logic [15:0] exp);
    q_spi.push_back(16'h0000);
    q_spi.push_back(exp);
    i_spi_host_model.frame(1'b1, a, nq, 2, 1'b1, 0);
    settle();
  endtask : rreg

  task automatic seq_rd(input int a, input logic [15:0] exp);
    @(negedge clock);
    q_seq.push_back(exp);
    tx_seq_active = 1'b1;
    tx_seq_re = 1'b1;
    tx_seq_addr = 6'(a);
    @(negedge clock);
    tx_seq_active = 1'b0;
    tx_seq_re = 1'b0;
    @(negedge clock);
  endtask : seq_rd

  task automatic rx_wr(input int a, input logic [15:0] d);
    @(negedge clock);
    rx_seq_active = 1'b1;
    rx_seq_we = 1'b1;
    rx_seq_addr = 6'(a);
    rx_seq_wdata = d;
    @(negedge clock);
    rx_seq_we = 1'b0;
    rx_seq_active = 1'b0;
  endtask : rx_wr

  // ---------------------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------------------
  initial begin
    sys_rst = 1'b1;
    {rx_seq_active, rx_seq_we, tx_seq_active, tx_seq_re} = 4'h0;
    {rx_seq_addr, tx_seq_addr, rx_seq_wdata} = 28'h0000000;
    void'($urandom(32'h9c5aa525));
    for (int i = 0; i < 65; i++) wq.push_back(16'($urandom));
    len = 7'($urandom_range(127, 1));
    repeat (12) @(negedge clock);
    sys_rst = 1'b0;
    settle();
    check_flag(tx_buffer_select, 1'b0, "select after reset");
    check_flag(irq, 1'b0, "irq after reset");
    rreg(`ADDR_TX_PKT_CTL, `RST_TX_PKT_CTL);
    wreg(`ADDR_TX_PKT_CTL, {1'b1, 8'h00, len});
    check_flag(tx_buffer_select, 1'b1, "select set");
    check_word({9'h000, tx_length}, {9'h000, len}, "length");
    rreg(`ADDR_TX_PKT_CTL, {1'b1, 8'h00, len});
    i_spi_host_model.frame(1'b0, `ADDR_TX_BUF_PORT, wq, 4, 1'b0, 0);
    for (int i = 0; i < 4; i++) seq_rd(i, wq[i]);
    i_spi_host_model.frame(1'b0, `ADDR_TX_BUF_PORT, {wq[5], wq[6]}, 2, 1'b0, 0);
    seq_rd(0, wq[5]);
    seq_rd(1, wq[6]);
    seq_rd(2, wq[2]);
    wreg(`ADDR_TX_PKT_CTL, {1'b0, 8'h00, len});
    i_spi_host_model.frame(1'b0, `ADDR_TX_BUF_PORT, {wq[7]}, 1, 1'b0, 0);
    seq_rd(0, wq[7]);
    wreg(`ADDR_TX_PKT_CTL, {1'b1, 8'h00, len});
    seq_rd(0, wq[5]);
    // Overrun with the mask clear and then set: the flag rises both times, the request only once.
    for (int m = 0; m < 2; m++) begin
      wreg(`ADDR_IRQ_MASK, m ? 16'h1000 : 16'h0000);
      rreg(`ADDR_IRQ_MASK, m ? 16'h1000 : 16'h0000);
      i_spi_host_model.frame(1'b0, `ADDR_TX_BUF_PORT, wq, 65, 1'b0, 0);
      settle();
      check_flag(irq, 1'(m), "overrun request");
      seq_rd(0, wq[0]);
      seq_rd(63, wq[63]);
      rreg(`ADDR_IRQ_FLAGS, 16'h4000);
      check_flag(irq, 1'b0, "request after status read");
      rreg(`ADDR_IRQ_FLAGS, 16'h0000);
    end
    wreg(`ADDR_IRQ_MASK, 16'h0800);
    for (int i = 0; i < 5; i++) rx_wr(i, wq[10 + i]);
    for (int p = 0; p < 2; p++) begin
      q_spi.push_back(16'h0000);
      for (int i = 0; i < 3; i++) q_spi.push_back(wq[10 + i]);
      i_spi_host_model.frame(1'b1, `ADDR_RX_BUF_PORT, nq, 4, 1'b1, 0);
    end
    fork
      i_spi_host_model.frame(1'b1, `ADDR_RX_BUF_PORT, nq, 3, 1'b0, 0);
      begin
        repeat (40) @(negedge clock);
        rx_wr(5, 16'h1234);
      end
    join
    settle();
    check_flag(irq, 1'b1, "receive contention request");
    rreg(`ADDR_IRQ_FLAGS, 16'h2000);
    q_spi.push_back(16'h0000);
    for (int i = 0; i < 5; i++) q_spi.push_back(wq[10 + i]);
    q_spi.push_back(16'h1234);
    i_spi_host_model.frame(1'b1, `ADDR_RX_BUF_PORT, nq, 7, 1'b1, 0);
    fork
      i_spi_host_model.frame(1'b0, `ADDR_TX_BUF_PORT, wq, 2, 1'b0, 0);
      begin
        repeat (40) @(negedge clock);
        seq_rd(0, wq[0]);
      end
    join
    settle();
    check_flag(irq, 1'b1, "transmit contention request");
    rreg(`ADDR_IRQ_FLAGS, 16'h2000);
    i_spi_host_model.frame(1'b1, `ADDR_SOFT_RESET, nq, 0, 1'b0, 2000);
    settle();
    check_flag(soft_reset, 1'b0, "reset on read");
    rreg(`ADDR_TX_PKT_CTL, {1'b1, 8'h00, len});
    fork
      i_spi_host_model.frame(1'b0, `ADDR_SOFT_RESET, nq, 0, 1'b0, 3000);
      begin
        n = 0;
        while (soft_reset !== 1'b1 && n < 200) begin
          @(negedge clock);
          n++;
        end
        check_flag(soft_reset, 1'b1, "reset after header");
        repeat (20) @(negedge clock);
        check_flag(soft_reset, 1'b1, "reset while selected");
      end
    join
    settle();
    check_flag(soft_reset, 1'b0, "reset after release");
    check_flag(tx_buffer_select, 1'b0, "select default");
    rreg(`ADDR_TX_PKT_CTL, `RST_TX_PKT_CTL);
    rreg(`ADDR_IRQ_MASK, `RST_IRQ_MASK);
    seq_rd(0, wq[7]);
    settle();
    check_flag(1'(q_spi.size() == 0 && q_seq.size() == 0), 1'b1, "results outstanding");
    wrap_up();
  end
endmodule : tb_spi_packet_buffer_access
`default_nettype wire
